// ==== common/lmq_pkg.sv ====
// Purpose: constants for the page-addressed queue register bank
// Assumes: 32-bit aligned word accesses, byte offsets as printed
// Notes:   offsets above 0x070 beyond the bank are decoded as unmapped
package lmq_pkg;
    // ==========================================================
    // register offsets
    localparam logic [11:0] LMQ_OFF_DEV_FEAT       = 12'h010;
    localparam logic [11:0] LMQ_OFF_DEV_FEAT_SEL   = 12'h014;
    localparam logic [11:0] LMQ_OFF_DRV_FEAT       = 12'h020;
    localparam logic [11:0] LMQ_OFF_DRV_FEAT_SEL   = 12'h024;
    localparam logic [11:0] LMQ_OFF_PAGE_SIZE      = 12'h028;
    localparam logic [11:0] LMQ_OFF_RING_SEL       = 12'h030;
    localparam logic [11:0] LMQ_OFF_RING_CAP       = 12'h034;
    localparam logic [11:0] LMQ_OFF_RING_COUNT     = 12'h038;
    localparam logic [11:0] LMQ_OFF_RING_ALIGN     = 12'h03C;
    localparam logic [11:0] LMQ_OFF_RING_PFN       = 12'h040;
    localparam logic [11:0] LMQ_OFF_DOORBELL       = 12'h050;
    localparam logic [11:0] LMQ_OFF_EVT_FLAGS      = 12'h060;
    localparam logic [11:0] LMQ_OFF_EVT_CLEAR      = 12'h064;
    localparam logic [11:0] LMQ_OFF_STATUS         = 12'h070;
    // ==========================================================
    // reset values and field layout
    localparam logic [31:0] LMQ_RST_WORD           = 32'h0000_0000;
    localparam logic [31:0] LMQ_RST_PAGE_SIZE      = 32'h0000_1000;
    localparam int          LMQ_EVT_BITS           = 2;
    localparam int          LMQ_DOORBELL_BITS      = 16;
    // ==========================================================
    // access state
    typedef enum logic [1:0] {
        LMQ_IDLE = 2'b00,
        LMQ_RDATA = 2'b01
    } lmq_state_t;
endpackage

// ==== rtl/lmq_regs.sv ====
// Purpose: register bank for the page-addressed queue transport
// Assumes: driver makes 32-bit aligned accesses, one per cycle
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/100ps

// What this block does
// [R1] driver writes page size before queue use
// [R2] driver picks power-of-two page size
// [R3] queue address is page frame times size
// [R4] selector picks ring for per-ring registers
// [R5] ring indices start at zero
// [R6] capacity reads limit, zero if unavailable
// [R7] driver reads capacity only while inactive
// [R8] element count stored per ring
// [R9] used ring alignment stored per ring
// [R10] page frame write records queue location
// [R11] page frame zero never counts valid
// [R12] driver stops ring by writing zero frame
// [R13] page frame read returns current value
// [R14] device features chosen by word select
// [R15] accepted driver features are recorded
// [R16] driver features stored by word select
// [R17] doorbell write services a ring index
// [R18] event bits stick until acknowledged
// [R19] interrupt asserted while any event set
// [R20] status zero write resets, clears frames
// [R21] wrong-direction accesses ignored, read zero
// [R22] out-of-range ring reads zero capacity
module lmq_regs
    import lmq_pkg::*;
#(
    parameter int          NUM_RINGS = 4,
    parameter int          IDX_W     = 2,
    parameter int          FEAT_WORDS = 2,
    parameter logic [31:0] RING_MAX  = 32'h0000_0100
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    // register access
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic [11:0]            reg_addr_i,
    input  wire logic [31:0]            reg_wdata_i,
    output logic      [31:0]            reg_rdata_o,
    output logic                        reg_rvalid_o,
    // device side
    input  wire logic [32*FEAT_WORDS-1:0] dev_features_i,
    input  wire logic [LMQ_EVT_BITS-1:0]  event_set_i,
    output logic      [32*FEAT_WORDS-1:0] drv_features_o,
    output logic                        doorbell_o,
    output logic      [LMQ_DOORBELL_BITS-1:0] doorbell_ring_o,
    output logic                        irq_o,
    output logic                        dev_reset_o,
    output logic      [63:0]            ring_addr_o,
    output logic                        ring_addr_valid_o
);
    initial begin
        if (FEAT_WORDS < 1 || NUM_RINGS < 1 || (1 << IDX_W) < NUM_RINGS)
            $error("lmq_regs: bad parameters");
    end

    // ==========================================================
    // decode
    wire wr_dev_sel  = reg_wr_i && reg_addr_i == LMQ_OFF_DEV_FEAT_SEL;
    wire wr_drv_feat = reg_wr_i && reg_addr_i == LMQ_OFF_DRV_FEAT;
    wire wr_drv_sel  = reg_wr_i && reg_addr_i == LMQ_OFF_DRV_FEAT_SEL;
    wire wr_page     = reg_wr_i && reg_addr_i == LMQ_OFF_PAGE_SIZE;
    wire wr_ring_sel = reg_wr_i && reg_addr_i == LMQ_OFF_RING_SEL;
    wire wr_count    = reg_wr_i && reg_addr_i == LMQ_OFF_RING_COUNT;
    wire wr_align    = reg_wr_i && reg_addr_i == LMQ_OFF_RING_ALIGN;
    wire wr_pfn      = reg_wr_i && reg_addr_i == LMQ_OFF_RING_PFN;
    wire wr_bell     = reg_wr_i && reg_addr_i == LMQ_OFF_DOORBELL;
    wire wr_ack      = reg_wr_i && reg_addr_i == LMQ_OFF_EVT_CLEAR;
    wire wr_status   = reg_wr_i && reg_addr_i == LMQ_OFF_STATUS;
    wire status_zero = wr_status && reg_wdata_i == LMQ_RST_WORD;

    // ==========================================================
    // state
    logic [31:0]              dev_sel_reg;
    logic [31:0]              drv_sel_reg;
    logic [31:0]              page_size_reg;
    logic [31:0]              ring_sel_reg;
    logic [31:0]              status_reg;
    logic [LMQ_EVT_BITS-1:0]  evt_reg;
    logic [LMQ_EVT_BITS-1:0]  evt_next;
    logic [32*FEAT_WORDS-1:0] drv_feat_reg;
    logic [31:0]              rdata_reg;
    logic                     rvalid_reg;
    logic                     bell_reg;
    logic [LMQ_DOORBELL_BITS-1:0] bell_ring_reg;
    logic                     irq_reg;
    logic                     dev_reset_reg;
    logic [63:0]              ring_addr_reg;
    logic                     ring_valid_reg;

    // ==========================================================
    // per-ring table
    wire [1:0]       tbl_field = wr_count ? 2'h0 : (wr_align ? 2'h1 : 2'h2);
    wire             ring_in_range = ring_sel_reg < NUM_RINGS; // see [R22]
    wire             tbl_wr    = (wr_count || wr_align || wr_pfn)
                                 && ring_in_range;
    wire [IDX_W-1:0] ring_idx  = ring_sel_reg[IDX_W-1:0]; // see [R5]
    logic [31:0]     tbl_count;
    logic [31:0]     tbl_align;
    logic [31:0]     tbl_pfn;

    lmq_ring_table #(
        .NUM_RINGS (NUM_RINGS),
        .IDX_W     (IDX_W)
    ) u_table (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .wr_en_i     (tbl_wr),
        .wr_field_i  (tbl_field),
        .idx_i       (ring_idx),
        .wr_data_i   (reg_wdata_i),
        .clear_all_i (status_zero),
        .count_o     (tbl_count),
        .align_o     (tbl_align),
        .pfn_o       (tbl_pfn)
    );

    // ==========================================================
    // read mux
    function automatic logic [31:0] feat_word(
        input logic [32*FEAT_WORDS-1:0] v,
        input logic [31:0]              sel
    );
        logic [31:0] w;
        w = LMQ_RST_WORD;
        for (int i = 0; i < FEAT_WORDS; i++) begin
            if (sel == i)
                w = v[32*i +: 32];
        end
        return w;
    endfunction

    wire [31:0] pfn_rd = ring_in_range ? tbl_pfn : LMQ_RST_WORD;
    wire [31:0] cap_rd = ring_in_range ? RING_MAX : LMQ_RST_WORD; // see [R6]
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            LMQ_OFF_DEV_FEAT:  rd_mux = feat_word(dev_features_i,
                                                  dev_sel_reg); // see [R14]
            LMQ_OFF_RING_CAP:  rd_mux = cap_rd; // see [R22]
            LMQ_OFF_RING_PFN:  rd_mux = pfn_rd; // see [R13]
            LMQ_OFF_EVT_FLAGS: rd_mux = {{(32-LMQ_EVT_BITS){1'b0}},
                                         evt_reg}; // see [R18]
            LMQ_OFF_STATUS:    rd_mux = status_reg;
            default:           rd_mux = LMQ_RST_WORD; // see [R21]
        endcase
    end

    // events: set wins over acknowledge
    always_comb begin
        evt_next = (evt_reg & ~reg_wdata_i[LMQ_EVT_BITS-1:0]);
        if (!wr_ack)
            evt_next = evt_reg;
        evt_next = evt_next | event_set_i; // see [R18]
    end

    // first page address; frame zero is never valid
    wire [63:0] addr_calc = 64'(tbl_pfn) * 64'(page_size_reg); // see [R3]
    wire        addr_ok   = ring_in_range && tbl_pfn != LMQ_RST_WORD;

    // ==========================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            dev_sel_reg    <= LMQ_RST_WORD;
            drv_sel_reg    <= LMQ_RST_WORD;
            page_size_reg  <= LMQ_RST_PAGE_SIZE;
            ring_sel_reg   <= LMQ_RST_WORD;
            status_reg     <= LMQ_RST_WORD;
            evt_reg        <= '0;
            drv_feat_reg   <= '0;
            rdata_reg      <= LMQ_RST_WORD;
            rvalid_reg     <= 1'b0;
            bell_reg       <= 1'b0;
            bell_ring_reg  <= '0;
            irq_reg        <= 1'b0;
            dev_reset_reg  <= 1'b0;
            ring_addr_reg  <= '0;
            ring_valid_reg <= 1'b0;
        end else begin
            if (wr_dev_sel)
                dev_sel_reg <= reg_wdata_i; // see [R14]
            if (wr_drv_sel)
                drv_sel_reg <= reg_wdata_i; // see [R16]
            if (wr_page)
                page_size_reg <= reg_wdata_i; // see [R1]
            if (wr_ring_sel)
                ring_sel_reg <= reg_wdata_i; // see [R4]
            if (wr_status)
                status_reg <= reg_wdata_i;
            for (int i = 0; i < FEAT_WORDS; i++) begin
                if (wr_drv_feat && drv_sel_reg == i)
                    drv_feat_reg[32*i +: 32] <= reg_wdata_i; // see [R15] [R16]
            end
            if (status_zero)
                drv_feat_reg <= '0;
            evt_reg        <= status_zero ? '0 : evt_next;
            irq_reg        <= |evt_next && !status_zero; // see [R19]
            rdata_reg      <= reg_rd_i ? rd_mux : LMQ_RST_WORD;
            rvalid_reg     <= reg_rd_i;
            bell_reg       <= wr_bell; // see [R17]
            if (wr_bell)
                bell_ring_reg <= reg_wdata_i[LMQ_DOORBELL_BITS-1:0];
            dev_reset_reg  <= status_zero; // see [R20]
            ring_addr_reg  <= addr_ok ? addr_calc : 64'h0;
            ring_valid_reg <= addr_ok; // see [R11]
        end
    end

    assign reg_rdata_o       = rdata_reg;
    assign reg_rvalid_o      = rvalid_reg;
    assign drv_features_o    = drv_feat_reg;
    assign doorbell_o        = bell_reg;
    assign doorbell_ring_o   = bell_ring_reg;
    assign irq_o             = irq_reg;
    assign dev_reset_o       = dev_reset_reg;
    assign ring_addr_o       = ring_addr_reg;
    assign ring_addr_valid_o = ring_valid_reg;
endmodule // lmq_regs

// ==== rtl/lmq_ring_table.sv ====
// Purpose: per-ring storage of count, alignment and page frame
// Assumes: one write port, one combinational read port
// Notes:   clear_all zeroes every page frame at once
`timescale 1ns/100ps
module lmq_ring_table
    import lmq_pkg::*;
#(
    parameter int NUM_RINGS = 4,
    parameter int IDX_W     = 2
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // write port
    input  wire logic             wr_en_i,
    input  wire logic [1:0]       wr_field_i,
    input  wire logic [IDX_W-1:0] idx_i,
    input  wire logic [31:0]      wr_data_i,
    input  wire logic             clear_all_i,
    // read port
    output logic      [31:0]      count_o,
    output logic      [31:0]      align_o,
    output logic      [31:0]      pfn_o
);
    // ==========================================================
    // storage
    logic [31:0] count_reg [NUM_RINGS];
    logic [31:0] align_reg [NUM_RINGS];
    logic [31:0] pfn_reg   [NUM_RINGS];

    initial begin
        if (NUM_RINGS < 1 || (1 << IDX_W) < NUM_RINGS)
            $error("ring table: bad NUM_RINGS or IDX_W");
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NUM_RINGS; i++) begin
            if (!resetn_i) begin
                count_reg[i] <= LMQ_RST_WORD;
                align_reg[i] <= LMQ_RST_WORD;
                pfn_reg[i]   <= LMQ_RST_WORD;
            end else if (clear_all_i) begin
                pfn_reg[i]   <= LMQ_RST_WORD; // see [R20]
            end else if (wr_en_i && int'(idx_i) == i) begin
                case (wr_field_i)
                    2'h0: count_reg[i] <= wr_data_i; // see [R8]
                    2'h1: align_reg[i] <= wr_data_i; // see [R9]
                    2'h2: pfn_reg[i]   <= wr_data_i; // see [R10] [R12]
                    default: ;
                endcase
            end
        end
    end

    // idx beyond the table reads zero
    wire idx_ok = int'(idx_i) < NUM_RINGS;
    assign count_o = idx_ok ? count_reg[idx_i] : LMQ_RST_WORD; // see [R4]
    assign align_o = idx_ok ? align_reg[idx_i] : LMQ_RST_WORD;
    assign pfn_o   = idx_ok ? pfn_reg[idx_i]   : LMQ_RST_WORD; // see [R13]
endmodule // lmq_ring_table

// ==== test/lmq_drv_model.sv ====
// Purpose: driver-side model issuing register accesses
// Assumes: one strobe cycle per access, idle cycle between
// Notes:   released address and data show the inverse value
`timescale 1ns/100ps
module lmq_drv_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [11:0] addr_o,
    output logic      [31:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 12'hFFF;
        wdata_o = 32'h0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        d = (rvalid_i === 1'b1) ? rdata_i : 32'hBAD0_BAD0;
    endtask
endmodule // lmq_drv_model

// ==== test/lmq_regs_assertions.sv ====
// Purpose: port-level checks of the queue register bank
// Assumes: single clock, sync active-low reset
// Notes:   status zero write is the only bulk clear
`timescale 1ns/100ps
module lmq_regs_chk (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic [1:0]  event_set_i,
    input wire logic        doorbell_o,
    input wire logic [15:0] doorbell_ring_o,
    input wire logic        irq_o,
    input wire logic        dev_reset_o,
    input wire logic        ring_addr_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // =============================================
    // decodes
    wire logic st0 = reg_wr_i && reg_addr_i == 12'h070 && reg_wdata_i == 0;
    wire logic wo  = reg_rd_i && reg_addr_i inside {12'h014, 12'h020,
        12'h024, 12'h028, 12'h030, 12'h038, 12'h03C, 12'h050, 12'h064};
    wire logic bw  = reg_wr_i && reg_addr_i == 12'h050;
    wire logic ack = reg_wr_i && reg_addr_i == 12'h064;
    // =============================================
    // properties
    property p_rd_ans;
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("no answer");
    property p_idle;
        !reg_rd_i |=> reg_rdata_o == 32'h0 && !reg_rvalid_o;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle data");
    property p_wo;
        wo |=> reg_rdata_o == 32'h0;
    endproperty
    a_wo: assert property (p_wo)
        else $error("wo read data");
    property p_bell;
        bw |=> doorbell_o && doorbell_ring_o == $past(reg_wdata_i[15:0]);
    endproperty
    a_bell: assert property (p_bell)
        else $error("doorbell");
    property p_bell_pulse;
        doorbell_o && !bw |=> !doorbell_o;
    endproperty
    a_bell_pulse: assert property (p_bell_pulse)
        else $error("doorbell held");
    property p_irq;
        event_set_i != 2'h0 && !st0 |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq missing");
    property p_hold;
        irq_o && !reg_wr_i |=> irq_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag lost");
    property p_ack;
        ack && reg_wdata_i[1:0] == 2'h3 && event_set_i == 2'h0 |=> !irq_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("flag kept");
    property p_evt_hi;
        reg_rd_i && reg_addr_i == 12'h060 |=> reg_rdata_o[31:2] == 30'h0;
    endproperty
    a_evt_hi: assert property (p_evt_hi)
        else $error("undefined flag");
    property p_rst;
        st0 |=> dev_reset_o;
    endproperty
    a_rst: assert property (p_rst)
        else $error("no reset pulse");
    property p_clr;
        dev_reset_o |=> !ring_addr_valid_o;
    endproperty
    a_clr: assert property (p_clr)
        else $error("frame kept");
    property p_zero;
        reg_wr_i && reg_addr_i == 12'h040 && reg_wdata_i == 0
            ##1 !reg_wr_i |=> !ring_addr_valid_o;
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero valid");
endmodule // lmq_regs_chk
bind lmq_regs lmq_regs_chk chk_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .event_set_i(event_set_i),
    .doorbell_o(doorbell_o), .doorbell_ring_o(doorbell_ring_o),
    .irq_o(irq_o), .dev_reset_o(dev_reset_o),
    .ring_addr_valid_o(ring_addr_valid_o)
);

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the queue register bank
// Assumes: accesses go through the driver model
// Notes:   expectations come from bench functions, saved values and literals
`timescale 1ns/100ps
module testbench;
    import lmq_pkg::*;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        wr, rd, rv, db, irq, drst, av;
    logic [11:0] addr;
    logic [31:0] wd, rdat, v, ps;
    logic [15:0] ring;
    logic [63:0] dfeat = 64'h0, ofeat, raddr;
    logic [1:0]  ev = 2'h0;
    logic [31:0] pfn [4];
    logic [31:0] dv [3];
    logic [32:0] ex;
    int          miscompares = 0;
    int          tests_run = 0;
    always #12.5 clk_i = ~clk_i;
    lmq_regs dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rdat), .reg_rvalid_o(rv), .dev_features_i(dfeat),
        .event_set_i(ev), .drv_features_o(ofeat), .doorbell_o(db),
        .doorbell_ring_o(ring), .irq_o(irq), .dev_reset_o(drst),
        .ring_addr_o(raddr), .ring_addr_valid_o(av));
    lmq_drv_model drv_u (.clk_i(clk_i), .rdata_i(rdat), .rvalid_i(rv),
        .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));
    function automatic logic [31:0] cap(input logic [31:0] s);
        return (s < 32'h4) ? 32'h0000_0100 : 32'h0;
    endfunction
    function automatic logic [63:0] ra(input logic [31:0] p, s);
        return {32'h0, p} * {32'h0, s};
    endfunction
    task automatic chk(input logic [71:0] g, e, input string m);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        miscompares++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hE6B3));
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        drv_u.wr(12'h034, 32'h0);
        for (int s = 0; s < 6; s++) begin
            drv_u.wr(12'h030, s);
            drv_u.rd(12'h034, v);
            chk(v, cap(s), "capacity");
        end
        $display("test capacity done");
        ps = 32'h1 << (12 + $urandom % 4);
        drv_u.wr(12'h028, ps);
        for (int r = 0; r < 4; r++) begin
            pfn[r] = $urandom % 32'hFFFFF + 1;
            drv_u.wr(12'h030, r);
            drv_u.wr(12'h038, 32'h80);
            drv_u.wr(12'h03C, ps);
            drv_u.wr(12'h040, pfn[r]);
        end
        for (int r = 3; r >= 0; r--) begin
            drv_u.wr(12'h030, r);
            drv_u.rd(12'h040, v);
            chk(v, pfn[r], "frame");
            chk({av, raddr}, {1'b1, ra(pfn[r], ps)}, "addr");
            drv_u.rd(12'h038, v);
            chk(v, 32'h0, "wo read");
        end
        drv_u.wr(12'h030, 32'h5);
        drv_u.wr(12'h040, 32'h1234);
        drv_u.rd(12'h040, v);
        chk({av, v}, 33'h0, "out of range");
        drv_u.wr(12'h030, 32'h1);
        drv_u.rd(12'h040, v);
        chk(v, pfn[1], "ring kept");
        $display("test rings done");
        dfeat <= {$urandom, $urandom};
        for (int w = 0; w < 3; w++) begin
            dv[w] = $urandom;
            drv_u.wr(12'h014, w);
            drv_u.rd(12'h010, v);
            chk(v, (w < 2) ? dfeat[32*w+:32] : 32'h0, "dev");
            drv_u.wr(12'h024, w);
            drv_u.wr(12'h020, dv[w]);
        end
        @(negedge clk_i);
        chk(ofeat, {dv[1], dv[0]}, "drv feature");
        v = $urandom;
        drv_u.wr(12'h050, v);
        @(negedge clk_i);
        chk({db, ring}, {1'b1, v[15:0]}, "doorbell");
        @(negedge clk_i);
        chk({db, ring}, {1'b0, v[15:0]}, "doorbell pulse");
        $display("test features done");
        @(posedge clk_i);
        ev <= 2'h3;
        @(posedge clk_i);
        ev <= 2'h0;
        for (int b = 0; b < 3; b++) begin
            ex = {b < 2, (32'h3 << b) & 32'h3};
            drv_u.rd(12'h060, v);
            chk({irq, v}, ex, "events");
            drv_u.wr(12'h064, 32'h1 << b);
        end
        @(posedge clk_i);
        ev <= 2'h1;
        @(posedge clk_i);
        ev <= 2'h0;
        fork
            drv_u.wr(12'h064, 32'h1);
            begin
                @(posedge clk_i);
                ev <= 2'h1;
                @(posedge clk_i);
                ev <= 2'h0;
            end
        join
        drv_u.rd(12'h060, v);
        chk({irq, v}, 33'h1_0000_0001, "set wins");
        drv_u.wr(12'h064, 32'h3);
        drv_u.rd(12'h060, v);
        chk({irq, v}, 33'h0, "acked");
        drv_u.wr(12'h030, 32'h1);
        drv_u.wr(12'h040, 32'h0);
        drv_u.rd(12'h040, v);
        chk({av, v}, 33'h0, "stopped");
        drv_u.wr(12'h070, 32'h1);
        @(negedge clk_i);
        chk(drst, 1'b0, "no reset");
        @(posedge clk_i);
        ev <= 2'h1;
        @(posedge clk_i);
        ev <= 2'h0;
        drv_u.wr(12'h070, 32'h0);
        @(negedge clk_i);
        chk(drst, 1'b1, "reset pulse");
        chk(ofeat, 64'h0, "features cleared");
        for (int r = 0; r < 4; r++) begin
            drv_u.wr(12'h030, r);
            drv_u.rd(12'h040, v);
            chk({av, v}, 33'h0, "cleared");
        end
        drv_u.rd(12'h060, v);
        chk({irq, v}, 33'h0, "flags cleared");
        drv_u.rd(12'h0A0, v);
        chk(v, 32'h0, "unmapped");
        $display("test events done");
        // hard reset in mid-run: page size back to its reset value
        drv_u.wr(12'h028, 32'h0000_8000);
        @(posedge clk_i);
        ev <= 2'h2;
        @(posedge clk_i);
        ev <= 2'h0;
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        drv_u.rd(12'h060, v);
        chk({irq, v}, 33'h0, "reset flags");
        drv_u.wr(12'h040, 32'h3);
        drv_u.rd(12'h040, v);
        chk(v, 32'h3, "reset frame");
        ps = LMQ_RST_PAGE_SIZE;
        chk({av, raddr}, {1'b1, ra(32'h3, ps)}, "reset addr");
        $display("test reset done");
        finish_test();
    end
endmodule // testbench
